// *** common/nvmc_map.vh ***
// register map, field positions and constants of the data eeprom controller
`ifndef NVMC_MAP_VH
`define NVMC_MAP_VH

// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define NVMC_IDX_CTRL 14'h0760
`define NVMC_IDX_ADDRL 14'h0762
`define NVMC_IDX_ADDRU 14'h0764
`define NVMC_IDX_KEY 14'h0766
`define NVMC_IDX_STAT 14'h0768

// ************************************************************
// control fields
// ************************************************************
`define NVMC_CTRL_START 15
`define NVMC_CTRL_PERMIT 14
`define NVMC_CTRL_ABORT 13
`define NVMC_CTRL_TIMED 8
`define NVMC_STAT_DONE 0
`define NVMC_CTRL_RESET 16'h0000
`define NVMC_KEY_FIRST 8'h55
`define NVMC_KEY_SECOND 8'haa

// ************************************************************
// operation codes
// ************************************************************
`define NVMC_OP_WORD_ERASE 7'h44
`define NVMC_OP_BLOCK_ERASE 7'h45
`define NVMC_OP_WORD_PROG 7'h04
`define NVMC_OP_BLOCK_PROG 7'h0a

// ************************************************************
// eeprom window and timing
// ************************************************************
`define NVMC_EE_FIRST 24'h7ff000
`define NVMC_EE_LAST 24'h7ffffe
`define NVMC_CLK_NS 100
`define NVMC_WRITE_TIME_NS 2000000
`define NVMC_WRITE_CYCLES (`NVMC_WRITE_TIME_NS / `NVMC_CLK_NS)
`define NVMC_RESP_OKAY 2'b00
`define NVMC_RESP_SLVERR 2'b10

`endif

// *** verification/nvmc_bench.sv ***
// self-checking bench for the data eeprom controller
`timescale 1ns/100ps
`include "nvmc_map.vh"
module nvmc_bench;
  localparam [15:0] A_CTRL = {`NVMC_IDX_CTRL, 2'h0};
  localparam [15:0] A_ADRL = {`NVMC_IDX_ADDRL, 2'h0};
  localparam [15:0] A_ADRU = {`NVMC_IDX_ADDRU, 2'h0};
  localparam [15:0] A_KEY = {`NVMC_IDX_KEY, 2'h0};
  localparam [15:0] A_STAT = {`NVMC_IDX_STAT, 2'h0};
  reg aclk = 1'h0, aresetn = 1'h0, power_on_reset = 1'h1;
  reg master_clear_reset = 1'h0, watchdog_timeout = 1'h0;
  reg [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hf;
  reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, arr_done = 1'h0;
  reg table_store_low = 1'h0, table_load_low = 1'h0;
  reg [23:0] table_addr = 24'h0, ta, base, tadr, ra;
  reg [15:0] table_wdata = 16'h0, arr_rdata = 16'h0, tl_data;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, table_rvalid, arr_load, arr_start, arr_abort, arr_read;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] table_rdata, arr_wdata;
  wire [23:0] arr_addr, arr_raddr;
  wire [6:0] arr_op;
  wire nvm_done_flag;
  reg [31:0] rnd = 32'h7dcf, rd;
  reg [1:0] resp;
  reg [6:0] op, st_op;
  reg [23:0] st_addr;
  reg [39:0] loads[$];
  reg [39:0] exp_l[0:15];
  integer mismatches = 0, checks_done = 0, cycles = 0;
  integer starts = 0, aborts = 0, k, i, n, s0, a0;

  nvmc_top i_dut (.aclk, .aresetn, .power_on_reset, .master_clear_reset,
    .watchdog_timeout, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .table_store_low, .table_load_low, .table_addr,
    .table_wdata, .table_rdata, .table_rvalid, .arr_addr, .arr_wdata,
    .arr_load, .arr_start, .arr_op, .arr_abort, .arr_read, .arr_raddr,
    .arr_rdata, .arr_done, .nvm_done_flag);

  always #50 aclk = ~aclk;

  // ************************************************************
  // helpers
  // ************************************************************
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task test_done;
    begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk_val(input string what, input [39:0] exp, input [39:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("[ERR] %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task chk_resp(input [1:0] exp, input [1:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("[ERR] response expected %h seen %h", exp, got);
      end
    end
  endtask
  task axi_w(input [15:0] a, input [31:0] d);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      @(posedge aclk);
      while (s_axi_bvalid !== 1'h1) begin
        if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
        if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        @(posedge aclk);
      end
      resp = s_axi_bresp;
      s_axi_bready <= 1'h0;
      @(posedge aclk);
    end
  endtask
  task axi_r(input [15:0] a);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      @(posedge aclk);
      while (s_axi_rvalid !== 1'h1) begin
        if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        @(posedge aclk);
      end
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'h0;
      @(posedge aclk);
    end
  endtask
  task rchk(input [15:0] a, input [31:0] e, input [31:0] m, input string w);
    begin
      axi_r(a);
      chk_resp(`NVMC_RESP_OKAY, resp);
      chk_val(w, e, rd & m);
    end
  endtask
  // mode 0 proper, 1 no keys, 2 key pair split, 3 permit clear
  task start_op(input [6:0] o, input integer mode);
    begin
      axi_w(A_CTRL, {16'h0, (mode == 3) ? 16'h0 : 16'h4000} | o);
      if (mode != 1) axi_w(A_KEY, {24'h0, `NVMC_KEY_FIRST});
      if (mode == 2) axi_w(A_ADRL, {16'h0, ta[15:0]});
      if (mode != 1) axi_w(A_KEY, {24'h0, `NVMC_KEY_SECOND});
      axi_w(A_CTRL, 32'hc000 | o);
    end
  endtask
  task tbl(input st, input [23:0] a, input [15:0] d);
    begin
      table_addr <= a;
      table_wdata <= d;
      table_store_low <= st;
      table_load_low <= !st;
      @(posedge aclk);
      table_store_low <= 1'h0;
      table_load_low <= 1'h0;
      repeat (4) @(posedge aclk);
    end
  endtask
  task wait_start(input integer s);
    integer w;
    begin
      w = 0;
      while (starts == s && w < 200) begin
        @(negedge aclk);
        w = w + 1;
      end
      @(posedge aclk);
    end
  endtask
  // completion time varies, so the bench never assumes a fixed count
  task finish_op;
    begin
      rnd = lfsr(rnd);
      repeat (4 + rnd[3:0]) @(posedge aclk);
      arr_done <= 1'h1;
      @(posedge aclk);
      arr_done <= 1'h0;
      @(posedge aclk);
    end
  endtask
  always @(posedge aclk) begin
    if (arr_load === 1'h1) loads.push_back({arr_addr, arr_wdata});
    if (arr_start === 1'h1) begin
      starts = starts + 1;
      st_op = arr_op;
      st_addr = arr_addr;
    end
    if (arr_abort === 1'h1) aborts = aborts + 1;
    if (arr_read === 1'h1) ra = arr_raddr;
    if (table_rvalid === 1'h1) tl_data = table_rdata;
    cycles = cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      test_done;
    end
  end

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    power_on_reset <= 1'h0;
    @(posedge aclk);
    rchk(A_CTRL, 32'h0, 32'hffffffff, "control");
    rchk(A_KEY, 32'h0, 32'hffffffff, "key");
    axi_r(16'h1dfc);
    chk_resp(`NVMC_RESP_SLVERR, resp);
    rnd = lfsr(rnd);
    ta = `NVMC_EE_FIRST | {12'h0, rnd[11:1], 1'h0};
    arr_rdata <= rnd[31:16];
    tbl(1'h1, ta, rnd[15:0]);
    tbl(1'h1, 24'h7fe000, 16'h1234);
    tbl(1'h0, ta, 16'h0);
    tbl(1'h0, 24'h7fe000, 16'h0);
    chk_val("table load", rnd[31:16], tl_data);
    chk_val("read addr", ta, ra);
    rchk(A_ADRL, {16'h0, ta[15:0]}, 32'hffff, "addr low");
    rchk(A_ADRU, {24'h0, ta[23:16]}, 32'hff, "addr upper");
    $display("test reset and table done");
    for (k = 1; k < 4; k = k + 1) begin
      s0 = starts;
      start_op(`NVMC_OP_WORD_ERASE, k);
      repeat (4) @(posedge aclk);
      chk_val("refused launch", s0, starts);
      rchk(A_CTRL, 32'h0, 32'h8000, "start refused");
    end
    $display("test refusals done");
    for (k = 0; k < 4; k = k + 1) begin
      op = (k == 0) ? `NVMC_OP_WORD_ERASE : (k == 1) ? `NVMC_OP_BLOCK_ERASE :
        (k == 2) ? `NVMC_OP_WORD_PROG : `NVMC_OP_BLOCK_PROG;
      n = (k == 3) ? 16 : (k == 2) ? 1 : 0;
      base = ta & 24'hffffe0;
      loads.delete();
      for (i = 0; i < n; i = i + 1) begin
        rnd = lfsr(rnd);
        tadr = (n == 1) ? ta : base | {19'h0, i[3:0], 1'h0};
        exp_l[i] = {tadr, rnd[15:0]};
        tbl(1'h1, tadr, rnd[15:0]);
      end
      s0 = starts;
      start_op(op, 0);
      wait_start(s0);
      chk_val("launches", s0 + 1, starts);
      chk_val("op code", op, st_op);
      chk_val("target", (k & 1) ? base : ta, st_addr);
      chk_val("latch words", n, loads.size());
      for (i = 0; i < n; i = i + 1)
        chk_val("latch", exp_l[i], loads[i]);
      axi_w(A_CTRL, 32'h0);
      rchk(A_CTRL, 32'h8000, 32'h8000, "start held");
      finish_op;
      rchk(A_CTRL, 32'h0, 32'h8000, "start cleared");
      rchk(A_STAT, 32'h1, 32'h1, "done flag");
      axi_w(A_STAT, 32'h1);
      rchk(A_STAT, 32'h0, 32'h1, "done cleared");
    end
    $display("test operations done");
    for (k = 0; k < 2; k = k + 1) begin
      tbl(1'h1, ta, 16'h0);
      s0 = starts;
      a0 = aborts;
      start_op(`NVMC_OP_WORD_PROG, 0);
      wait_start(s0);
      if (k == 1) watchdog_timeout <= 1'h1;
      else master_clear_reset <= 1'h1;
      repeat (3) @(posedge aclk);
      aresetn <= 1'h0;
      master_clear_reset <= 1'h0;
      watchdog_timeout <= 1'h0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      chk_val("aborts", a0 + 1, aborts);
      rchk(A_CTRL, 32'h2000, 32'ha000, "abort flag");
      rchk(A_ADRL, {16'h0, ta[15:0]}, 32'hffff, "addr kept");
      rchk(A_STAT, 32'h0, 32'h1, "no done");
      axi_w(A_CTRL, 32'h0);
    end
    $display("test aborts done");
    test_done;
  end
endmodule

// *** verification/nvmc_top_asserts.sv ***
// port checker for the data eeprom controller
`timescale 1ns/100ps
`include "nvmc_map.vh"
module nvmc_checker (
  input wire aclk,
  input wire aresetn,
  input wire power_on_reset,
  input wire master_clear_reset,
  input wire watchdog_timeout,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire table_load_low,
  input wire [23:0] table_addr,
  input wire [15:0] table_rdata,
  input wire table_rvalid,
  input wire arr_start,
  input wire arr_abort,
  input wire arr_read,
  input wire [15:0] arr_rdata,
  input wire arr_done,
  input wire nvm_done_flag
);
  reg busy_reg;
  wire in_win = table_addr >= `NVMC_EE_FIRST && table_addr <= `NVMC_EE_LAST;
  // an array operation is in flight from launch until done or abort
  always @(posedge aclk) begin
    if (!aresetn || power_on_reset || arr_done || arr_abort) busy_reg <= 1'h0;
    else if (arr_start) busy_reg <= 1'h1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_write_refuse: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rvalid_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_load_answer: assert property (
    table_load_low && in_win |=> arr_read ##2
      (table_rvalid && table_rdata == $past(arr_rdata)))
    else $error("table load result wrong");
  a_load_outside: assert property (
    table_load_low && !in_win |=> !arr_read)
    else $error("array read outside window");
  a_done_flag: assert property (
    busy_reg && arr_done && !power_on_reset |=> nvm_done_flag)
    else $error("done flag not set");
  a_flag_sticky: assert property (
    $fell(nvm_done_flag) |-> $rose(s_axi_bvalid) || $past(power_on_reset))
    else $error("done flag cleared by hardware");
  a_start_single: assert property (
    arr_start |=> !arr_start [*8])
    else $error("repeated launch");
  a_abort_event: assert property (
    busy_reg && $rose(master_clear_reset || watchdog_timeout)
      |-> ##[0:2] arr_abort)
    else $error("abort missing");
  a_abort_cause: assert property (
    arr_abort |-> busy_reg)
    else $error("abort while idle");
  c_launch: cover property (arr_start);
  c_abort: cover property (arr_abort);
  c_load: cover property (table_rvalid);
  c_done: cover property (busy_reg && arr_done);
endmodule

bind nvmc_top nvmc_checker i_chk (.aclk(aclk), .aresetn(aresetn),
  .power_on_reset(power_on_reset), .master_clear_reset(master_clear_reset),
  .watchdog_timeout(watchdog_timeout), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .table_load_low(table_load_low),
  .table_addr(table_addr), .table_rdata(table_rdata),
  .table_rvalid(table_rvalid), .arr_start(arr_start),
  .arr_abort(arr_abort), .arr_read(arr_read), .arr_rdata(arr_rdata),
  .arr_done(arr_done), .nvm_done_flag(nvm_done_flag));

// *** verilog/nvmc_latch_mem.v ***
// write latch memory with registered read data
`timescale 1ns/100ps
module nvmc_latch_mem #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire aclk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// *** verilog/nvmc_top.v ***
// data eeprom controller with axi4-lite registers and table port
`timescale 1ns/100ps
`include "nvmc_map.vh"
module nvmc_top #(
  parameter LATCH_DEPTH = 16,
  parameter LATCH_AW = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire power_on_reset,
  input wire master_clear_reset,
  input wire watchdog_timeout,
  input wire [15:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [15:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire table_store_low,
  input wire table_load_low,
  input wire [23:0] table_addr,
  input wire [15:0] table_wdata,
  output reg [15:0] table_rdata,
  output reg table_rvalid,
  output reg [23:0] arr_addr,
  output reg [15:0] arr_wdata,
  output reg arr_load,
  output reg arr_start,
  output reg [6:0] arr_op,
  output reg arr_abort,
  output reg arr_read,
  output reg [23:0] arr_raddr,
  input wire [15:0] arr_rdata,
  input wire arr_done,
  output reg nvm_done_flag
);
  localparam ST_IDLE = 3'd0;
  localparam ST_LOAD_RD = 3'd1;
  localparam ST_LOAD_WR = 3'd2;
  localparam ST_LAUNCH = 3'd3;
  localparam ST_WAIT = 3'd4;

  // ************************************************************
  // register state
  // ************************************************************
  reg start_reg;
  reg permit_reg;
  reg program_abort_flag;
  reg timed_op_select;
  reg [6:0] operation_code;
  reg [15:0] nvm_address_low;
  reg [7:0] nvm_address_upper;
  reg [2:0] state_reg;
  reg [6:0] op_reg;
  reg [LATCH_AW-1:0] cnt_reg;
  reg [LATCH_AW-1:0] last_reg;
  reg [23:0] base_reg;
  reg read_pend_reg;
  reg aw_full_reg;
  reg w_full_reg;
  reg [13:0] aw_idx_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;

  wire [15:0] ctrl_value;
  wire [15:0] latch_rdata;
  wire unlocked;
  wire reset_event;
  wire wr_fire;
  wire wr_ctrl;
  wire wr_key;
  wire wr_other;
  wire wr_mapped;
  wire [15:0] ctrl_wr_val;
  wire [15:0] addrl_wr_val;
  wire [7:0] addru_wr_val;
  wire op_known;
  wire op_block;
  wire op_prog;
  wire start_ok;
  wire [13:0] ar_idx;
  wire table_in_range_st;
  wire table_in_range_ld;
  wire [23:0] target_addr;

  function [15:0] merge;
    input [15:0] old_v;
    input [15:0] new_v;
    input [1:0] strb;
    begin
      merge[7:0] = strb[0] ? new_v[7:0] : old_v[7:0];
      merge[15:8] = strb[1] ? new_v[15:8] : old_v[15:8];
    end
  endfunction

  assign ctrl_value = {start_reg, permit_reg, program_abort_flag, 4'h0,
    timed_op_select, 1'b0, operation_code};
  assign reset_event = master_clear_reset | watchdog_timeout;
  assign target_addr = {nvm_address_upper, nvm_address_low};
  assign table_in_range_st = (table_addr >= `NVMC_EE_FIRST) &&
    (table_addr <= `NVMC_EE_LAST);
  assign table_in_range_ld = table_in_range_st;

  // ************************************************************
  // axi write decode
  // ************************************************************
  assign wr_fire = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  assign wr_ctrl = wr_fire && aw_idx_reg == `NVMC_IDX_CTRL;
  assign wr_key = wr_fire && aw_idx_reg == `NVMC_IDX_KEY && wstrb_reg[0];
  assign wr_mapped = wr_ctrl || aw_idx_reg == `NVMC_IDX_KEY ||
    aw_idx_reg == `NVMC_IDX_ADDRL || aw_idx_reg == `NVMC_IDX_ADDRU ||
    aw_idx_reg == `NVMC_IDX_STAT;
  assign wr_other = wr_fire && !wr_ctrl && !wr_key;
  assign ctrl_wr_val = merge(ctrl_value, wdata_reg[15:0], wstrb_reg[1:0]);
  assign addrl_wr_val = merge(nvm_address_low, wdata_reg[15:0],
    wstrb_reg[1:0]);
  assign addru_wr_val = wstrb_reg[0] ? wdata_reg[7:0] : nvm_address_upper;
  assign op_block = ctrl_wr_val[6:0] == `NVMC_OP_BLOCK_ERASE ||
    ctrl_wr_val[6:0] == `NVMC_OP_BLOCK_PROG;
  assign op_prog = ctrl_wr_val[6:0] == `NVMC_OP_WORD_PROG ||
    ctrl_wr_val[6:0] == `NVMC_OP_BLOCK_PROG;
  assign op_known = op_block || op_prog ||
    ctrl_wr_val[6:0] == `NVMC_OP_WORD_ERASE;
  // permit is taken from before this write, so one write cannot set both
  assign start_ok = wr_ctrl && ctrl_wr_val[`NVMC_CTRL_START] &&
    !start_reg && permit_reg && unlocked && op_known &&
    state_reg == ST_IDLE;
  assign ar_idx = s_axi_araddr[15:2];

  nvmc_unlock u_unlock (
    .aclk(aclk),
    .aresetn(aresetn),
    .key_wr(wr_key),
    .key_data(wdata_reg[7:0]),
    .ctrl_wr(wr_ctrl),
    .other_wr(wr_other),
    .unlocked(unlocked)
  );

  nvmc_latch_mem #(
    .WIDTH(16),
    .DEPTH(LATCH_DEPTH),
    .AW(LATCH_AW)
  ) u_latch (
    .aclk(aclk),
    .wr_en(table_store_low & table_in_range_st),
    .wr_addr(table_addr[LATCH_AW:1]),
    .wr_data(table_wdata),
    .rd_addr(cnt_reg),
    .rd_data(latch_rdata)
  );

  // ************************************************************
  // axi handshakes
  // ************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `NVMC_RESP_OKAY;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_idx_reg <= 14'h0000;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `NVMC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        s_axi_awready <= 1'b0;
        aw_idx_reg <= s_axi_awaddr[15:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `NVMC_RESP_OKAY : `NVMC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `NVMC_RESP_OKAY;
        case (ar_idx)
          `NVMC_IDX_CTRL: s_axi_rdata <= {16'h0000, ctrl_value};
          `NVMC_IDX_ADDRL: s_axi_rdata <= {16'h0000, nvm_address_low};
          `NVMC_IDX_ADDRU: s_axi_rdata <= {24'h000000, nvm_address_upper};
          `NVMC_IDX_KEY: s_axi_rdata <= 32'h00000000;
          `NVMC_IDX_STAT: s_axi_rdata <= {31'h00000000, nvm_done_flag};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `NVMC_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ************************************************************
  // registers kept across system reset
  // ************************************************************
  // address and abort survive the system reset so software can retry
  always @(posedge aclk) begin
    if (power_on_reset) begin
      nvm_address_low <= 16'h0000;
      nvm_address_upper <= 8'h00;
      program_abort_flag <= 1'b0;
    end else begin
      if (aresetn && reset_event && state_reg != ST_IDLE) begin
        program_abort_flag <= 1'b1;
      end else if (wr_ctrl && wstrb_reg[1]) begin
        program_abort_flag <= ctrl_wr_val[`NVMC_CTRL_ABORT];
      end
      // table stores inside the eeprom window capture their address as the last target
      if (table_store_low && table_in_range_st) begin
        nvm_address_low <= table_addr[15:0];
        nvm_address_upper <= table_addr[23:16];
      end else if (wr_fire && aw_idx_reg == `NVMC_IDX_ADDRL) begin
        nvm_address_low <= addrl_wr_val;
      end else if (wr_fire && aw_idx_reg == `NVMC_IDX_ADDRU) begin
        nvm_address_upper <= addru_wr_val;
      end
    end
  end

  // ************************************************************
  // control register and operation sequencer
  // ************************************************************
  always @(posedge aclk) begin
    if (!aresetn || power_on_reset) begin
      start_reg <= 1'b0;
      permit_reg <= 1'b0;
      timed_op_select <= 1'b0;
      operation_code <= 7'h00;
      state_reg <= ST_IDLE;
      op_reg <= 7'h00;
      cnt_reg <= {LATCH_AW{1'b0}};
      last_reg <= {LATCH_AW{1'b0}};
      base_reg <= 24'h000000;
      arr_addr <= 24'h000000;
      arr_wdata <= 16'h0000;
      arr_load <= 1'b0;
      arr_start <= 1'b0;
      arr_op <= 7'h00;
      arr_abort <= 1'b0;
      nvm_done_flag <= 1'b0;
    end else begin
      arr_load <= 1'b0;
      arr_start <= 1'b0;
      arr_abort <= 1'b0;
      if (wr_ctrl) begin
        // only hardware clears permit through reset; software owns it
        permit_reg <= ctrl_wr_val[`NVMC_CTRL_PERMIT];
        timed_op_select <= ctrl_wr_val[`NVMC_CTRL_TIMED];
        operation_code <= ctrl_wr_val[6:0];
      end
      // done flag: write one to clear, a completion in the same cycle wins
      if (state_reg == ST_WAIT && arr_done) begin
        nvm_done_flag <= 1'b1;
      end else if (wr_fire && aw_idx_reg == `NVMC_IDX_STAT &&
          wstrb_reg[0] && wdata_reg[`NVMC_STAT_DONE]) begin
        nvm_done_flag <= 1'b0;
      end
      if (start_ok) begin
        start_reg <= 1'b1;
        op_reg <= ctrl_wr_val[6:0];
        cnt_reg <= {LATCH_AW{1'b0}};
        last_reg <= op_block ? {LATCH_AW{1'b1}} : {LATCH_AW{1'b0}};
        base_reg <= op_block ? {target_addr[23:LATCH_AW+1],
          {(LATCH_AW+1){1'b0}}} : target_addr;
        if (!op_prog) begin
          state_reg <= ST_LAUNCH;
        end else if (op_block) begin
          state_reg <= ST_LOAD_RD;
        end else begin
          cnt_reg <= target_addr[LATCH_AW:1];
          last_reg <= target_addr[LATCH_AW:1];
          state_reg <= ST_LOAD_RD;
        end
      end
      // permit is not looked at after launch, so clearing it cannot stop us
      case (state_reg)
        ST_IDLE: begin
        end
        ST_LOAD_RD: begin
          state_reg <= ST_LOAD_WR;
        end
        ST_LOAD_WR: begin
          arr_load <= 1'b1;
          arr_wdata <= latch_rdata;
          arr_addr <= (last_reg == cnt_reg && !(op_reg ==
            `NVMC_OP_BLOCK_PROG)) ? base_reg :
            {base_reg[23:LATCH_AW+1], cnt_reg, 1'b0};
          if (cnt_reg == last_reg) begin
            state_reg <= ST_LAUNCH;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
            state_reg <= ST_LOAD_RD;
          end
        end
        ST_LAUNCH: begin
          arr_start <= 1'b1;
          arr_op <= op_reg;
          arr_addr <= base_reg;
          state_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          // the array timing varies, so only its done pulse, an abort or a reset ends the cycle
          if (arr_done) begin
            start_reg <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
      if (reset_event && state_reg != ST_IDLE) begin
        arr_abort <= 1'b1;
        start_reg <= 1'b0;
        state_reg <= ST_IDLE;
      end
    end
  end

  // ************************************************************
  // table load path, never waits on a running operation
  // ************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      arr_read <= 1'b0;
      arr_raddr <= 24'h000000;
      read_pend_reg <= 1'b0;
      table_rdata <= 16'h0000;
      table_rvalid <= 1'b0;
    end else begin
      arr_read <= table_load_low & table_in_range_ld;
      if (table_load_low && table_in_range_ld) begin
        arr_raddr <= table_addr;
      end
      read_pend_reg <= arr_read;
      table_rvalid <= read_pend_reg;
      if (read_pend_reg) begin
        table_rdata <= arr_rdata;
      end
    end
  end
endmodule

// *** verilog/nvmc_unlock.v ***
// key sequence tracker that arms a single start
`timescale 1ns/100ps
`include "nvmc_map.vh"
module nvmc_unlock (
  input wire aclk,
  input wire aresetn,
  input wire key_wr,
  input wire [7:0] key_data,
  input wire ctrl_wr,
  input wire other_wr,
  output wire unlocked
);
  localparam S_IDLE = 2'd0;
  localparam S_GOT_FIRST = 2'd1;
  localparam S_ARMED = 2'd2;

  reg [1:0] state_reg;
  reg [1:0] state_next;

  assign unlocked = (state_reg == S_ARMED);

  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (key_wr && key_data == `NVMC_KEY_FIRST) begin
          state_next = S_GOT_FIRST;
        end
      end
      S_GOT_FIRST: begin
        if (key_wr && key_data == `NVMC_KEY_SECOND) begin
          state_next = S_ARMED;
        end else if (key_wr || ctrl_wr || other_wr) begin
          state_next = S_IDLE;
        end
      end
      S_ARMED: begin
        // the control write after the keys uses up the unlock either way
        if (key_wr || ctrl_wr || other_wr) begin
          state_next = S_IDLE;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule
